// *** shared/rcp_pkg.sv ***
// Purpose: constants and types for the reset cause and power-on-clear logic
// Assumes: byte-wide cpu register port, 40 MHz system clock
// Notes: peripheral init table index order is listed by the rcp_periph_e names
package rcp_pkg;

    localparam logic [15:0] RCP_ADDR_BO_CTRL = 16'hff50;
    localparam logic [15:0] RCP_ADDR_BO_LEVEL = 16'hff51;
    localparam logic [15:0] RCP_ADDR_RESET_FLAGS = 16'hff54;

    localparam int RCP_WDT_FLAG_BIT = 4;
    localparam int RCP_LVI_FLAG_BIT = 0;
    localparam int RCP_BO_ENABLE_BIT = 7;
    localparam int RCP_BO_MODE_BIT = 1;
    localparam int RCP_BO_BELOW_BIT = 0;

    localparam logic [7:0] RCP_FLAGS_RESET = 8'h00;
    localparam logic [7:0] RCP_BO_CTRL_RESET = 8'h00;
    localparam logic [3:0] RCP_BO_LEVEL_RESET = 4'h0;
    localparam logic [7:0] RCP_BO_CTRL_WMASK = 8'h82;
    localparam logic [7:0] RCP_UNMAPPED_READ = 8'h00;

    localparam int RCP_PERIPH_N = 13;

    typedef enum logic [3:0] {
        RCP_SERIAL_MODE = 4'h0,
        RCP_SERIAL_CONTROL = 4'h1,
        RCP_SERIAL_BAUD = 4'h2,
        RCP_SERIAL_RX_BUF = 4'h3,
        RCP_SERIAL_TX_BUF = 4'h4,
        RCP_SERIAL_RX_ERR = 4'h5,
        RCP_SERIAL_TX_ERR = 4'h6,
        RCP_IRQ_MASK_A = 4'h7,
        RCP_IRQ_MASK_B = 4'h8,
        RCP_IRQ_REQUEST_A = 4'h9,
        RCP_IRQ_REQUEST_B = 4'ha,
        RCP_EXT_MODE_A = 4'hb,
        RCP_EXT_MODE_B = 4'hc
    } rcp_periph_e;

    localparam logic [7:0] RCP_PERIPH_INIT [RCP_PERIPH_N] = '{
        8'h01, 8'h16, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00,
        8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00
    };

    typedef struct packed {
        logic wdt_flag;
        logic lvi_flag;
        logic bo_enable;
        logic bo_mode;
        logic [3:0] bo_level;
        logic [7:0] rdata;
        logic int_rst;
    } rcp_state_t;

endpackage

// *** design/rcp_init_reg.sv ***
// Purpose: one byte register that returns to a fixed value on internal reset
// Assumes: clear has priority over the owning peripheral's load
// Notes: used once per peripheral register that needs a defined start value
module rcp_init_reg
    import rcp_pkg::*;
#(
    parameter logic [7:0] INIT = 8'h00
)
(
    input wire logic sys_clk_i,
    input wire logic clear_i,
    input wire logic load_i,
    input wire logic [7:0] data_i,
    output logic [7:0] q_o
);

    logic [7:0] q;
    logic [7:0] next_q;

    always_comb
    begin
        next_q = q;
        if (clear_i)
        begin
            next_q = INIT;
        end
        else if (load_i)
        begin
            next_q = data_i;
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        q <= next_q;
    end

    assign q_o = q;

endmodule

// *** design/rcp_reset_ctrl.sv ***
// Purpose: reset cause flags, power-on-clear reset and reset-time register init
// Assumes: reset_i is the synchronous pin reset; detector requests are levels
// Notes: flags update while the internal reset is active, priority pin > poc > wdt > lvi
module rcp_reset_ctrl
    import rcp_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic poc_below_i,
    input wire logic wdt_req_i,
    input wire logic lvi_req_i,
    input wire logic bo_below_i,
    input wire logic [15:0] addr_i,
    input wire logic rd_i,
    input wire logic wr_i,
    input wire logic [7:0] wdata_i,
    input wire logic [RCP_PERIPH_N-1:0] periph_we_i,
    input wire logic [7:0] periph_wdata_i,
    output logic [7:0] rdata_o,
    output logic internal_reset_o,
    output logic bo_enable_o,
    output logic bo_mode_o,
    output logic [3:0] bo_level_o,
    output logic [RCP_PERIPH_N-1:0][7:0] periph_regs_o
);

    rcp_state_t st;
    rcp_state_t next_st;
    logic src_poc;
    logic src_wdt;
    logic src_lvi;
    logic any_src;
    logic [7:0] flags_byte;
    logic [7:0] bo_ctrl_byte;

    ////////////////////////////////////////////////////////////////////////////
    // reset sources

    // poc comparator drives reset straight from power-up, no pin needed
    assign src_poc = poc_below_i;
    assign src_wdt = wdt_req_i && !src_poc;
    assign src_lvi = lvi_req_i && !src_poc && !wdt_req_i;
    assign any_src = src_poc || wdt_req_i || lvi_req_i;

    always_comb
    begin
        flags_byte = 8'h00;
        flags_byte[RCP_WDT_FLAG_BIT] = st.wdt_flag;
        flags_byte[RCP_LVI_FLAG_BIT] = st.lvi_flag;
        bo_ctrl_byte = 8'h00;
        bo_ctrl_byte[RCP_BO_ENABLE_BIT] = st.bo_enable;
        bo_ctrl_byte[RCP_BO_MODE_BIT] = st.bo_mode;
        bo_ctrl_byte[RCP_BO_BELOW_BIT] = bo_below_i && st.bo_enable;
    end

    ////////////////////////////////////////////////////////////////////////////
    // state update

    always_comb
    begin
        next_st = st;
        next_st.int_rst = any_src;
        // read data is captured from the old flags on the same edge as the clear
        next_st.rdata = RCP_UNMAPPED_READ;
        if (rd_i)
        begin
            if (addr_i == RCP_ADDR_RESET_FLAGS)
            begin
                next_st.rdata = flags_byte;
                next_st.wdt_flag = 1'b0;
                next_st.lvi_flag = 1'b0;
            end
            else if (addr_i == RCP_ADDR_BO_CTRL)
            begin
                next_st.rdata = bo_ctrl_byte;
            end
            else if (addr_i == RCP_ADDR_BO_LEVEL)
            begin
                next_st.rdata = {4'h0, st.bo_level};
            end
        end
        if (wr_i)
        begin
            if (addr_i == RCP_ADDR_BO_CTRL)
            begin
                next_st.bo_enable = wdata_i[RCP_BO_ENABLE_BIT];
                next_st.bo_mode = wdata_i[RCP_BO_MODE_BIT];
            end
            else if (addr_i == RCP_ADDR_BO_LEVEL)
            begin
                next_st.bo_level = wdata_i[3:0];
            end
        end
        // reset events come last so a set wins over a read clear
        if (src_poc)
        begin
            next_st.wdt_flag = 1'b0;
            next_st.lvi_flag = 1'b0;
            next_st.bo_enable = 1'b0;
            next_st.bo_mode = 1'b0;
            next_st.bo_level = RCP_BO_LEVEL_RESET;
        end
        else if (src_wdt)
        begin
            next_st.wdt_flag = 1'b1;
            next_st.lvi_flag = st.lvi_flag;
            next_st.bo_enable = 1'b0;
            next_st.bo_mode = 1'b0;
            next_st.bo_level = RCP_BO_LEVEL_RESET;
        end
        else if (src_lvi)
        begin
            // brownout settings deliberately left untouched here
            next_st.lvi_flag = 1'b1;
            next_st.wdt_flag = st.wdt_flag;
            next_st.bo_enable = st.bo_enable;
            next_st.bo_mode = st.bo_mode;
            next_st.bo_level = st.bo_level;
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            st.wdt_flag <= 1'b0;
            st.lvi_flag <= 1'b0;
            st.bo_enable <= RCP_BO_CTRL_RESET[RCP_BO_ENABLE_BIT];
            st.bo_mode <= RCP_BO_CTRL_RESET[RCP_BO_MODE_BIT];
            st.bo_level <= RCP_BO_LEVEL_RESET;
            st.rdata <= RCP_FLAGS_RESET;
            st.int_rst <= 1'b1;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign rdata_o = st.rdata;
    assign internal_reset_o = st.int_rst;
    assign bo_enable_o = st.bo_enable;
    assign bo_mode_o = st.bo_mode;
    assign bo_level_o = st.bo_level;

    ////////////////////////////////////////////////////////////////////////////
    // peripheral registers with defined values after any reset

    logic periph_clear;
    assign periph_clear = reset_i || any_src;

    genvar gi;
    generate
        for (gi = 0; gi < RCP_PERIPH_N; gi++)
        begin : g_periph
            rcp_init_reg #(
                .INIT(RCP_PERIPH_INIT[gi])
            ) u_reg (
                .sys_clk_i(sys_clk_i),
                .clear_i(periph_clear),
                .load_i(periph_we_i[gi]),
                .data_i(periph_wdata_i),
                .q_o(periph_regs_o[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);

    logic flags_read;
    assign flags_read = rd_i && (addr_i == RCP_ADDR_RESET_FLAGS);

    read_clear_a: assert property (flags_read && !any_src |=> !st.wdt_flag && !st.lvi_flag)
        else $error("cause flags not cleared by read");
    read_value_a: assert property (flags_read |=> rdata_o == $past(flags_byte))
        else $error("read did not return pre-clear flags");
    poc_clear_a: assert property (poc_below_i |=> !st.wdt_flag && !st.lvi_flag && !bo_enable_o && bo_level_o == 4'h0)
        else $error("poc reset did not clear flags and settings");
    wdt_set_a: assert property (wdt_req_i && !poc_below_i |=> st.wdt_flag && st.lvi_flag == $past(st.lvi_flag))
        else $error("watchdog reset flag handling wrong");
    wdt_bo_clear_a: assert property (wdt_req_i && !poc_below_i |=> !bo_enable_o && !bo_mode_o && bo_level_o == 4'h0)
        else $error("watchdog reset kept brownout settings");
    lvi_hold_a: assert property (lvi_req_i && !poc_below_i && !wdt_req_i |=>
        st.lvi_flag && st.wdt_flag == $past(st.wdt_flag) && $stable(bo_level_o) && $stable(bo_enable_o))
        else $error("brownout reset flag or settings wrong");
    flag_read_zero_a: assert property (flags_read |=> (rdata_o & 8'hee) == 8'h00)
        else $error("reserved cause bits read nonzero");
    // one cycle per comparator sample: reset may drop once the supply recovers
    poc_hold_a: assert property (poc_below_i |=> internal_reset_o)
        else $error("internal reset dropped while supply low");
    release_a: assert property (!any_src |=> !internal_reset_o)
        else $error("internal reset not released");
    irq_mask_a: assert property (any_src |=> periph_regs_o[RCP_IRQ_MASK_A] == 8'hff
        && periph_regs_o[RCP_IRQ_REQUEST_A] == 8'h00)
        else $error("interrupt registers not initialised");
    serial_init_a: assert property (any_src |=> periph_regs_o[RCP_SERIAL_MODE] == 8'h01
        && periph_regs_o[RCP_SERIAL_CONTROL] == 8'h16 && periph_regs_o[RCP_SERIAL_BAUD] == 8'hff)
        else $error("serial registers not initialised");

    wdt_then_read_c: cover property (wdt_req_i ##1 !any_src [*2] ##1 flags_read);
    lvi_reset_c: cover property (st.bo_enable && lvi_req_i ##1 !any_src ##1 flags_read);
    poc_cycle_c: cover property (poc_below_i ##1 !poc_below_i ##1 !internal_reset_o);

endmodule

// *** sim/rcp_cpu_model.sv ***
// Purpose: cpu software side that reads the reset cause and brownout registers
// Assumes: byte accesses only, strobes launched at the falling edge
// Notes: the testbench calls these tasks hierarchically
module rcp_cpu_model
(
    input wire logic sys_clk_i,
    input wire logic internal_reset_i,
    input wire logic [7:0] rdata_i,
    output logic [15:0] addr_o,
    output logic rd_o,
    output logic wr_o,
    output logic [7:0] wdata_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        addr_o = 16'h0000;
        rd_o = 1'b0;
        wr_o = 1'b0;
        wdata_o = 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////////
    // whole byte read only, never a single bit
    task automatic rd_byte(input logic [15:0] a, output logic [7:0] d);
        @(negedge sys_clk_i);
        addr_o = a;
        rd_o = 1'b1;
        @(negedge sys_clk_i);
        rd_o = 1'b0;
        addr_o = ~a; // released bus shows no stale address
        d = rdata_i;
    endtask

    task automatic wr_byte(input logic [15:0] a, input logic [7:0] d);
        @(negedge sys_clk_i);
        addr_o = a;
        wdata_o = d;
        wr_o = 1'b1;
        @(negedge sys_clk_i);
        wr_o = 1'b0;
        addr_o = ~a;
        wdata_o = ~d;
    endtask

    // software counter: sit out supply wobble before touching ports
    task automatic wait_release(input int n);
        int k;
        k = 0;
        while (internal_reset_i === 1'b1 && k < 100)
        begin
            @(negedge sys_clk_i);
            k++;
        end
        repeat (n) @(negedge sys_clk_i);
    endtask
endmodule

// *** sim/testbench.sv ***
// Purpose: self-checking bench for the reset cause and power-on-clear logic
// Assumes: inputs change at the falling edge, 40 MHz clock
// Notes: reset sources are pulsed for one cycle each by src; power-up holds pin for 6 cycles and poc for 9
`define CHK(got, exp) \
    begin compares++; if ((got) !== (exp)) begin n_fail++; \
    $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module testbench
    import rcp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic sys_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic poc_below_i = 1'b1;
    logic wdt_req_i = 1'b0;
    logic lvi_req_i = 1'b0;
    logic bo_below_i = 1'b0;
    logic [RCP_PERIPH_N-1:0] periph_we_i = '0;
    logic [7:0] periph_wdata_i = 8'h00;
    logic [15:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
    logic [7:0] rdata_o;
    logic internal_reset_o;
    logic bo_enable_o;
    logic bo_mode_o;
    logic [3:0] bo_level_o;
    logic [RCP_PERIPH_N-1:0][7:0] periph_regs_o;
    logic [7:0] d;
    int n_fail = 0;
    int compares = 0;
    // start values worked out independently of the design's table
    localparam logic [7:0] EXP_INIT [13] = '{8'h01, 8'h16, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00,
                                             8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00};

    always #12.5 sys_clk_i = ~sys_clk_i;

    rcp_reset_ctrl dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .poc_below_i(poc_below_i),
        .wdt_req_i(wdt_req_i), .lvi_req_i(lvi_req_i), .bo_below_i(bo_below_i), .addr_i(addr),
        .rd_i(rd), .wr_i(wr), .wdata_i(wdata), .periph_we_i(periph_we_i),
        .periph_wdata_i(periph_wdata_i), .rdata_o(rdata_o), .internal_reset_o(internal_reset_o),
        .bo_enable_o(bo_enable_o), .bo_mode_o(bo_mode_o), .bo_level_o(bo_level_o),
        .periph_regs_o(periph_regs_o));

    rcp_cpu_model cpu (.sys_clk_i(sys_clk_i), .internal_reset_i(internal_reset_o), .rdata_i(rdata_o),
        .addr_o(addr), .rd_o(rd), .wr_o(wr), .wdata_o(wdata));

    ////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic check_init;
        for (int i = 0; i < RCP_PERIPH_N; i++)
            `CHK(periph_regs_o[i], EXP_INIT[i])
    endtask

    // 0 pin, 1 power-on-clear, 2 watchdog, 3 brownout
    task automatic src(input int s);
        @(negedge sys_clk_i);
        case (s)
            0: reset_i = 1'b1;
            1: poc_below_i = 1'b1;
            2: wdt_req_i = 1'b1;
            default: lvi_req_i = 1'b1;
        endcase
        @(negedge sys_clk_i);
        `CHK(internal_reset_o, 1'b1)
        reset_i = 1'b0;
        poc_below_i = 1'b0;
        wdt_req_i = 1'b0;
        lvi_req_i = 1'b0;
        cpu.wait_release(2);
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
        cpu.rd_byte(a, d);
        `CHK(d, e)
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (6) @(negedge sys_clk_i);
        `CHK(internal_reset_o, 1'b1)
        reset_i = 1'b0;
        repeat (3) @(negedge sys_clk_i);
        `CHK(internal_reset_o, 1'b1)
        poc_below_i = 1'b0;
        cpu.wait_release(2);
        `CHK(internal_reset_o, 1'b0)
        check_init();
        rd_chk(RCP_ADDR_RESET_FLAGS, 8'h00);
        cpu.wr_byte(RCP_ADDR_BO_LEVEL, 8'h09);
        cpu.wr_byte(RCP_ADDR_BO_CTRL, 8'hff);
        rd_chk(RCP_ADDR_BO_CTRL, 8'h82);
        bo_below_i = 1'b1;
        rd_chk(RCP_ADDR_BO_CTRL, 8'h83);
        `CHK(bo_level_o, 4'h9)
        @(negedge sys_clk_i);
        periph_we_i = '1;
        periph_wdata_i = 8'h5a;
        @(negedge sys_clk_i);
        periph_we_i = '0;
        `CHK(periph_regs_o[0], 8'h5a)
        src(2);
        `CHK(bo_level_o, 4'h0)
        `CHK(bo_enable_o, 1'b0)
        check_init();
        rd_chk(RCP_ADDR_RESET_FLAGS, 8'h10);
        rd_chk(RCP_ADDR_RESET_FLAGS, 8'h00);
        src(2);
        cpu.wr_byte(RCP_ADDR_BO_LEVEL, 8'h09);
        cpu.wr_byte(RCP_ADDR_BO_CTRL, 8'h82);
        src(3);
        `CHK(bo_level_o, 4'h9)
        `CHK(bo_mode_o, 1'b1)
        rd_chk(RCP_ADDR_RESET_FLAGS, 8'h11);
        src(2);
        src(0);
        rd_chk(RCP_ADDR_RESET_FLAGS, 8'h00);
        src(3);
        src(1);
        rd_chk(RCP_ADDR_RESET_FLAGS, 8'h00);
        `CHK(bo_level_o, 4'h0)
        cpu.wr_byte(RCP_ADDR_RESET_FLAGS, 8'hff);
        rd_chk(RCP_ADDR_RESET_FLAGS, 8'h00);
        rd_chk(16'hff55, RCP_UNMAPPED_READ);
        tally_and_finish();
    end

    // whole sequence needs well under 1000 cycles
    initial
    begin
        #100000;
        n_fail++;
        tally_and_finish();
    end
endmodule
